/* rfs_pkg.sv */
// Constants and state layout for the dual RF synthesiser divider control
package rfs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] RFS_ADDR_DATA = 8'hB2;
    localparam logic [7:0] RFS_ADDR_CTRL = 8'hB3;
    localparam logic [7:0] RFS_ADDR_STAT = 8'hB4;
    localparam logic [7:0] RFS_ADDR_MASK = 8'hCE;

    // ----------------------------------------
    // Divider widths and data word layout
    // ----------------------------------------
    localparam int RFS_N_W = 20;
    localparam int RFS_R_W = 13;
    localparam int RFS_DW_SYNTH = 15;
    localparam int RFS_DW_SET = 14;
    localparam int RFS_DW_PART_HI = 13;
    localparam int RFS_DW_PART_LO = 12;
    localparam logic [1:0] RFS_PART_N_LO = 2'h0;
    localparam logic [1:0] RFS_PART_N_HI = 2'h1;
    localparam logic [1:0] RFS_PART_R_LO = 2'h2;
    localparam logic [1:0] RFS_PART_R_HI = 2'h3;

    // ----------------------------------------
    // Control fields, per synthesiser byte; REFSEL is shared and read from the low byte only
    // ----------------------------------------
    localparam int RFS_CTL_STRIDE = 8;
    localparam int RFS_CTL_EN = 0;
    localparam int RFS_CTL_SET = 1;
    localparam int RFS_CTL_TOL4 = 2;
    localparam int RFS_CTL_GAIN = 3;
    localparam int RFS_CTL_REFSEL = 4;

    // ----------------------------------------
    // Lock detector and reset values
    // ----------------------------------------
    localparam logic [2:0] RFS_TOL_ONE = 3'h1;
    localparam logic [2:0] RFS_TOL_FOUR = 3'h4;
    localparam logic [15:0] RFS_CTRL_RST = 16'h0000;
    localparam logic [15:0] RFS_MASK_RST = 16'h0000;

    typedef struct packed {
        logic [1:0][1:0][RFS_N_W-1:0] n_reg;
        logic [1:0][1:0][RFS_R_W-1:0] r_reg;
        logic [15:0] ctl;
        logic [15:0] mask;
        logic [1:0][RFS_N_W-1:0] n_cnt;
        logic [1:0][RFS_R_W-1:0] r_cnt;
        logic [1:0] up;
        logic [1:0] dn;
        logic [1:0][2:0] ph_cnt;
        logic [1:0][2:0] hist;
        logic [1:0] lock;
        logic [1:0] evt;
        logic [15:0] rdata;
        logic irq;
    } rfs_state_type;
endpackage

/* rfs_synth_ctrl.sv */
// Dual integer-N synthesiser dividers, phase detector and lock detector
`timescale 1ns/1ps
// Behaviour
// RULE1 - Two N/R register sets per synthesiser
// RULE2 - One control write swaps Tx/Rx set
// RULE3 - N counter 20 bits, R 13 bits
// RULE4 - R divides reference, N divides VCO
// RULE5 - Shared reference selects crystal or external
// RULE6 - Gain bit 3 or 11, 4:1 current
// RULE7 - Divider setup takes four data writes
// RULE8 - Host updates only idle or alternate set
// RULE9 - Control register alone selects active set
// RULE10 - Lock bits readable, maskable interrupt
// RULE11 - Locked to unlocked transition raises interrupt
// RULE12 - Tolerance one or four reference cycles
// RULE13 - Lock is majority of three measurements
// RULE14 - Lock bits mean phase lock only
// RULE15 - Host keeps comparison 2.5kHz to 200kHz
// RULE16 - Write-only interrupt mask register
// RULE17 - One interrupt per lock loss
// RULE18 - Set change applies at counter reload
module rfs_synth_ctrl import rfs_pkg::*; (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_xtal_ref_tick,
    input wire logic i_external_synth_ref_input,
    input wire logic [1:0] i_vco_tick,
    output logic [15:0] o_reg_rdata,
    output logic [1:0] o_pump_up,
    output logic [1:0] o_pump_dn,
    output logic [1:0] o_pump_current_set_high,
    output logic [1:0] o_synth_enable,
    output logic o_lock_irq
);
    rfs_state_type st_q;
    rfs_state_type st_d;
    logic ref_tick;
    logic [1:0] r_term;
    logic [1:0] n_term;
    logic [1:0] meas_done;
    logic [1:0] meas_pass;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic sy;
        logic se;
        logic [1:0] part;
        logic up_n;
        logic dn_n;
        logic [2:0] tol;
        logic [2:0] h;
        logic maj;
        sy = i_reg_wdata[RFS_DW_SYNTH];
        se = i_reg_wdata[RFS_DW_SET];
        part = i_reg_wdata[RFS_DW_PART_HI:RFS_DW_PART_LO];
        up_n = 1'b0;
        dn_n = 1'b0;
        tol = RFS_TOL_ONE;
        h = 3'h0;
        maj = 1'b0;
        st_d = st_q;
        r_term = 2'h0;
        n_term = 2'h0;
        meas_done = 2'h0;
        meas_pass = 2'h0;
        // RULE5 - shared reference select
        ref_tick = st_q.ctl[RFS_CTL_REFSEL] ? i_external_synth_ref_input : i_xtal_ref_tick;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                // RULE1 - set bit picks Tx or Rx copy
                // RULE7 - one quarter of setup per write
                RFS_ADDR_DATA: begin
                    unique case (part)
                        RFS_PART_N_LO: st_d.n_reg[sy][se][11:0] = i_reg_wdata[11:0];
                        RFS_PART_N_HI: st_d.n_reg[sy][se][19:12] = i_reg_wdata[7:0];
                        RFS_PART_R_LO: st_d.r_reg[sy][se][11:0] = i_reg_wdata[11:0];
                        RFS_PART_R_HI: st_d.r_reg[sy][se][12] = i_reg_wdata[0];
                    endcase
                end
                // RULE2 - single write swaps sets
                RFS_ADDR_CTRL: st_d.ctl = i_reg_wdata;
                // RULE16 - write-only mask
                RFS_ADDR_MASK: st_d.mask = i_reg_wdata;
                default: ;
            endcase
        end
        st_d.rdata = 16'h0000;
        if (i_reg_rd && i_reg_addr == RFS_ADDR_STAT) begin
            // RULE10 - lock state readable
            st_d.rdata = {12'h000, st_q.evt, st_q.lock};
            st_d.evt = 2'h0;
        end
        for (int s = 0; s < 2; s++) begin
            if (!st_q.ctl[s*RFS_CTL_STRIDE+RFS_CTL_EN]) begin
                st_d.r_cnt[s] = '0;
                st_d.n_cnt[s] = '0;
                st_d.up[s] = 1'b0;
                st_d.dn[s] = 1'b0;
                st_d.ph_cnt[s] = 3'h0;
            end else begin
                // RULE4 - R divides the reference
                if (ref_tick) begin
                    if (st_q.r_cnt[s] == '0) begin
                        r_term[s] = 1'b1;
                        // RULE18 - reload from current set
                        // RULE9 - set chosen by control only
                        st_d.r_cnt[s] = st_q.r_reg[s][st_q.ctl[s*RFS_CTL_STRIDE+RFS_CTL_SET]] - 13'h0001;
                    end else begin
                        st_d.r_cnt[s] = st_q.r_cnt[s] - 13'h0001;
                    end
                end
                // RULE3 - 20-bit feedback counter
                if (i_vco_tick[s]) begin
                    if (st_q.n_cnt[s] == '0) begin
                        n_term[s] = 1'b1;
                        // RULE18 - reload keeps whole cycles
                        st_d.n_cnt[s] = st_q.n_reg[s][st_q.ctl[s*RFS_CTL_STRIDE+RFS_CTL_SET]] - 20'h00001;
                    end else begin
                        st_d.n_cnt[s] = st_q.n_cnt[s] - 20'h00001;
                    end
                end
                up_n = st_q.up[s] | r_term[s];
                dn_n = st_q.dn[s] | n_term[s];
                // RULE12 - phase error counted in reference cycles
                if ((st_q.up[s] ^ st_q.dn[s]) && ref_tick && st_q.ph_cnt[s] != 3'h7) begin
                    st_d.ph_cnt[s] = st_q.ph_cnt[s] + 3'h1;
                end
                tol = st_q.ctl[s*RFS_CTL_STRIDE+RFS_CTL_TOL4] ? RFS_TOL_FOUR : RFS_TOL_ONE;
                if (up_n && dn_n) begin
                    // RULE14 - phase check only, no frequency test
                    meas_done[s] = 1'b1;
                    meas_pass[s] = (st_d.ph_cnt[s] <= tol);
                    up_n = 1'b0;
                    dn_n = 1'b0;
                    st_d.ph_cnt[s] = 3'h0;
                end
                st_d.up[s] = up_n;
                st_d.dn[s] = dn_n;
            end
            if (meas_done[s]) begin
                // RULE13 - three-entry history, majority vote
                h = {st_q.hist[s][1:0], meas_pass[s]};
                maj = (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
                st_d.hist[s] = h;
                st_d.lock[s] = maj;
                // RULE11 - locked to unlocked edge
                // RULE17 - only on falling vote, set beats read clear
                if (st_q.lock[s] && !maj) begin
                    st_d.evt[s] = 1'b1;
                end
            end
        end
        // RULE10 - mask gates the lock interrupts
        st_d.irq = |(st_d.evt & st_d.mask[1:0]);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
            st_q.ctl <= RFS_CTRL_RST;
            st_q.mask <= RFS_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_reg_rdata = st_q.rdata;
    assign o_pump_up = st_q.up;
    assign o_pump_dn = st_q.dn;
    // RULE6 - gain bits 3 and 11 pick 4:1 current
    assign o_pump_current_set_high = {st_q.ctl[RFS_CTL_STRIDE+RFS_CTL_GAIN], st_q.ctl[RFS_CTL_GAIN]};
    assign o_synth_enable = {st_q.ctl[RFS_CTL_STRIDE+RFS_CTL_EN], st_q.ctl[RFS_CTL_EN]};
    assign o_lock_irq = st_q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ctrl_write_takes: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE2
        (i_reg_wr && i_reg_addr == RFS_ADDR_CTRL) |=> st_q.ctl == $past(i_reg_wdata))
        else $error("control write not stored");
    a_gain_bit_out: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE6
        (i_reg_wr && i_reg_addr == RFS_ADDR_CTRL) |=> o_pump_current_set_high == {$past(i_reg_wdata[11]),
        $past(i_reg_wdata[3])})
        else $error("gain output does not follow bits 3 and 11");
    a_data_nlo_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE7
        (i_reg_wr && i_reg_addr == RFS_ADDR_DATA && i_reg_wdata[13:12] == RFS_PART_N_LO && !i_reg_wdata[15]
        && !i_reg_wdata[14]) |=> st_q.n_reg[0][0][11:0] == $past(i_reg_wdata[11:0]))
        else $error("N low part not loaded");
    a_disabled_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE18
        !o_synth_enable[0] |=> !o_pump_up[0] && !o_pump_dn[0])
        else $error("pump active while disabled");
    a_single_miss_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE13
        (st_q.hist[0] == 3'h7 && meas_done[0] && !meas_pass[0]) |=> o_synth_enable[0] -> st_q.lock[0])
        else $error("single miss cleared lock");
    a_unlock_event: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE11
        $fell(st_q.lock[0]) |-> st_q.evt[0])
        else $error("lock loss not flagged");
    a_no_repeat_irq: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE17
        (!st_q.lock[0] && !st_q.evt[0] && meas_done[0]) |=> !st_q.evt[0] || $past(i_reg_rd))
        else $error("event repeated while unlocked");
    a_status_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE10
        (i_reg_rd && i_reg_addr == RFS_ADDR_STAT) |=> o_reg_rdata[1:0] == $past(st_q.lock)
        && o_reg_rdata[15:4] == 12'h000)
        else $error("status read value wrong");
    a_mask_gates_irq: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE16
        (st_q.mask[1:0] == 2'h0) |-> !o_lock_irq)
        else $error("interrupt raised while masked");
    a_count_no_cut: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE18
        (o_synth_enable[0] && ref_tick && st_q.r_cnt[0] != 13'h0000)
        |=> st_q.r_cnt[0] == $past(st_q.r_cnt[0]) - 13'h0001)
        else $error("divider count cut short");
endmodule

/* rfs_vco_model.sv */
// Reference and VCO feedback tick model for the synthesiser bench
`timescale 1ns/1ps
module rfs_vco_model (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_vco_period,
    input wire logic i_ref_ext,
    output logic o_xtal_ref_tick,
    output logic o_ext_ref_tick,
    output logic [1:0] o_vco_tick
);
    logic [3:0] ref_cnt_q;
    logic [3:0] vco_cnt_q;

    // fixed comparison rate
    // Reference ticks every 4 clocks; the VCO runs free, as a real one does
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ref_cnt_q <= 4'h0;
            vco_cnt_q <= 4'h0;
        end else begin
            ref_cnt_q <= (ref_cnt_q == 4'h3) ? 4'h0 : ref_cnt_q + 4'h1;
            vco_cnt_q <= (vco_cnt_q >= i_vco_period - 4'h1) ? 4'h0 : vco_cnt_q + 4'h1;
        end
    end

    // one source live
    // Only the chosen source ticks, so a wrong select loses all reference
    assign o_xtal_ref_tick = (ref_cnt_q == 4'h0) && !i_ref_ext;
    assign o_ext_ref_tick = (ref_cnt_q == 4'h0) && i_ref_ext;
    assign o_vco_tick = {2{vco_cnt_q == 4'h0}};
endmodule

/* rfs_synth_ctrl_tb.sv */
// Self-checking bench for the dual synthesiser divider control
`timescale 1ns/1ps
module rfs_synth_ctrl_tb import rfs_pkg::*;;
    typedef struct packed {
        logic [15:0] ctl;
        logic [1:0] en;
        logic [1:0] gain;
    } rfs_row_type;
    logic clk, rst, wr, rd, ref_ext, xt, ex, irq;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, v, hits;
    logic [3:0] per;
    logic [1:0] vco, up, dn, gain, en;
    int err_total, cmp_count;
    rfs_row_type rows [5];

    rfs_synth_ctrl i_rfs_synth_ctrl (.i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_xtal_ref_tick(xt), .i_external_synth_ref_input(ex),
        .i_vco_tick(vco), .o_reg_rdata(rdata), .o_pump_up(up), .o_pump_dn(dn),
        .o_pump_current_set_high(gain), .o_synth_enable(en), .o_lock_irq(irq));
    rfs_vco_model i_rfs_vco_model (.i_clk(clk), .i_sys_rst(rst), .i_vco_period(per), .i_ref_ext(ref_ext),
        .o_xtal_ref_tick(xt), .o_ext_ref_tick(ex), .o_vco_tick(vco));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    // Four writes fill one set; parts may land in any order
    task div_wr(input logic s, input logic t, input logic [19:0] n, input logic [12:0] r);
        reg_wr(RFS_ADDR_DATA, {s, t, RFS_PART_N_LO, n[11:0]});
        reg_wr(RFS_ADDR_DATA, {s, t, RFS_PART_N_HI, 4'h0, n[19:12]});
        reg_wr(RFS_ADDR_DATA, {s, t, RFS_PART_R_LO, r[11:0]});
        reg_wr(RFS_ADDR_DATA, {s, t, RFS_PART_R_HI, 11'h000, r[12]});
    endtask
    task wait_lock(output logic [15:0] d);
        for (int i = 0; i < 80; i++) begin
            reg_rd(RFS_ADDR_STAT, d);
            if (d[0] === 1'b1) break;
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run is well under 1500 cycles; this 40000-cycle limit is far beyond it
    initial begin
        #400000;
        err_total++;
        finish_test;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
        per = 4'h4; ref_ext = 1'b0; err_total = 0; cmp_count = 0; hits = 16'h0000;
        rows = '{'{16'h0000, 2'h0, 2'h0}, '{16'h0008, 2'h0, 2'h1}, '{16'h0800, 2'h0, 2'h2},
                 '{16'h0101, 2'h3, 2'h0}, '{16'h0F0F, 2'h3, 2'h3}};
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk_pin("reset outputs", 2'h0, en | gain | up | dn);
        reg_rd(RFS_ADDR_STAT, v);
        chk_word("status after reset", 16'h0000, v);
        foreach (rows[i]) begin
            reg_wr(RFS_ADDR_CTRL, rows[i].ctl);
            chk_pin("enable", rows[i].en, en);
            chk_pin("pump gain", rows[i].gain, gain);
        end
        reg_wr(8'hB5, 16'h0000);
        chk_pin("enable after stray write", 2'h3, en);
        reg_rd(RFS_ADDR_CTRL, v);
        chk_word("control readback", 16'h0000, v);
        reg_wr(RFS_ADDR_CTRL, 16'h0000);
        div_wr(1'b0, 1'b0, 20'h00002, 13'h0002);
        ref_ext = 1'b1;
        reg_wr(RFS_ADDR_CTRL, 16'h0011);
        wait_lock(v);
        chk_pin("lock on external ref", 2'h1, v[1:0]);
        reg_rd(RFS_ADDR_STAT, v);
        reg_wr(RFS_ADDR_MASK, 16'h0001);
        // Slow VCO never aligns twice running, so lock must fall and stay down
        per = 4'hF;
        for (int i = 0; i < 600 && irq !== 1'b1; i++) @(negedge clk);
        chk_pin("lock interrupt", 2'h1, {1'b0, irq});
        reg_rd(RFS_ADDR_STAT, v);
        chk_word("status after loss", 16'h0004, v);
        chk_pin("interrupt cleared", 2'h0, {1'b0, irq});
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            if (irq !== 1'b0) hits++;
        end
        chk_word("interrupt repeats", 16'h0000, hits);
        per = 4'h4;
        div_wr(1'b0, 1'b1, 20'h00002, 13'h0002);
        ref_ext = 1'b0;
        // four-cycle tolerance absorbs the VCO phase left by the slow run
        reg_wr(RFS_ADDR_CTRL, 16'h0007);
        // Tx is now the alternate set
        div_wr(1'b0, 1'b0, 20'h00107, 13'h0005);
        wait_lock(v);
        chk_pin("lock on Rx set", 2'h1, v[1:0]);
        // Reset mid-run must drop control, mask and lock state together
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk_pin("enable after mid reset", 2'h0, en);
        chk_pin("interrupt after mid reset", 2'h0, {1'b0, irq});
        reg_rd(RFS_ADDR_STAT, v);
        chk_word("status after mid reset", 16'h0000, v);
        finish_test;
    end
endmodule
